/* File: hw/flash_guard_defs.svh */
// Constants for the serial flash front end: opcodes, status bits, resets.
// Assumes nothing; included by the protection and status design file only.
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

`define CMD_STATUS_WRITE   8'h01
`define CMD_PAGE_PROGRAM   8'h02
`define CMD_WRITE_DISABLE  8'h04
`define CMD_STATUS_READ    8'h05
`define CMD_WRITE_ENABLE   8'h06
`define CMD_SECTOR_ERASE   8'h20
`define CMD_SECTOR_ERASE_B 8'hd7
`define CMD_BLOCK_ERASE    8'hd8
`define CMD_CHIP_ERASE     8'h60
`define CMD_CHIP_ERASE_B   8'hc7

`define STAT_BUSY        0
`define STAT_WRITE_LATCH 1
`define STAT_LEVEL_LO    2
`define STAT_LEVEL_HI    4
`define STAT_FROM_BOTTOM 5
`define STAT_RESERVED    6
`define STAT_LOCK        7
`define STAT_NV_MASK     8'hbc
`define NV_RESET         8'h00

`define ADDR_LAST_BYTE   2'h2
`define PIN_SYNC_INIT    5'h17

`endif

/* File: hw/flash_guard_pkg.sv */
// Types shared by the serial flash front end.
// Assumes flash_guard_defs.svh holds the numeric constants.
package flash_guard_pkg;

  typedef enum logic [2:0] {
    st_cmd    = 3'b000,
    st_addr   = 3'b001,
    st_data   = 3'b010,
    st_read   = 3'b011,
    st_ignore = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    op_program = 2'b00,
    op_sector  = 2'b01,
    op_block   = 2'b10,
    op_chip    = 2'b11
  } op_kind_t;

endpackage : flash_guard_pkg

/* File: hw/pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes asynchronous pins; output follows once stages two and three agree.
`timescale 1ns/10ps
module pin_sync #(
  parameter int         WIDTH = 5,
  parameter logic [4:0] INIT  = 5'h17
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= INIT[WIDTH-1:0];
      stage2 <= INIT[WIDTH-1:0];
      stage3 <= INIT[WIDTH-1:0];
      level  <= INIT[WIDTH-1:0];
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end

endmodule : pin_sync

/* File: hw/spi_flash_protect_status.sv */
// Serial flash front end: serial framing, pause, status and protection.
// Assumes an array engine on mclk that takes op_start and ends with
// array_done, and a non-volatile store that restores nv_restore at power-up.
// What this block does and what it expects of the master
// R1: Sample input on rising, drive after falling edge
// R2: Work with clock idling low or high
// R3: Master keeps select low when pausing
// R4: Pause on request edges while clock low
// R5: Master changes pause request only clock low
// R6: Paused: output floats, inputs and clock ignored
// R7: Deselect in pause aborts; resume needs both
// R8: Status write refused when guard low, locked
// R9: Status bit 0 shows busy
// R10: While busy only status reads act
// R11: Bit 1 is write latch; gates program/erase
// R12: Latch cleared at power-up and completions
// R13: Protection bits 2..5, lock 7, 6 zero
// R14: Protection and lock bits are non-volatile
// R15: Refuse program/erase in protected region
// R16: Chip erase only with levels all zero
// R17: Top eighth, quarter, half when from-top
// R18: Bottom eighth, quarter, half when from-bottom
// R19: Level bit 2 protects all; zero protects none
// R20: Master sends write enable before writes
// R21: Status read repeats; status write one byte
// R22: MSB first; early deselect aborts command
// R23: Refused writes change nothing, stay not busy
`timescale 1ns/10ps
`include "flash_guard_defs.svh"
module spi_flash_protect_status #(
  parameter int AW = 19
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      sck,
  input  wire logic                      select_n,
  input  wire logic                      si,
  input  wire logic                      pause_request_n,
  input  wire logic                      write_guard_n,
  input  wire logic                      array_done,
  input  wire logic [7:0]                nv_restore,
  output logic                           so,
  output logic                           so_oe,
  output logic                           op_start,
  output flash_guard_pkg::op_kind_t      op_kind,
  output logic [AW-1:0]                  op_addr,
  output logic [7:0]                     prog_data,
  output logic                           prog_valid,
  output logic                           nv_store,
  output logic [7:0]                     nv_bits
);

  function automatic logic is_protected(input logic [AW-1:0] a,
                                        input logic [2:0]    lvl,
                                        input logic          bottom);
    logic [2:0] top;
    logic       hit;
    top = bottom ? ~a[AW-1 -: 3] : a[AW-1 -: 3];
    unique case (lvl[1:0])
      2'b01:   hit = (top == 3'h7);       // R17 R18
      2'b10:   hit = (top[2:1] == 2'h3);  // R17 R18
      2'b11:   hit = top[2];              // R17 R18
      default: hit = 1'b0;                // R19
    endcase
    return lvl[2] | hit;                  // R19
  endfunction : is_protected

  logic [4:0]                sync_level;
  logic                      cs_s;
  logic                      sck_s;
  logic                      si_s;
  logic                      hold_s;
  logic                      guard_s;
  logic                      cs_q;
  logic                      sck_q;
  logic                      hold_q;
  logic                      paused;
  logic                      active;
  logic                      sck_rise;
  logic                      sck_fall;
  logic                      cs_rise;
  flash_guard_pkg::phase_t   phase;
  logic [2:0]                bit_cnt;
  logic [1:0]                addr_cnt;
  logic [7:0]                shreg;
  logic [7:0]                rx_byte;
  logic [7:0]                cmd;
  logic [AW-1:0]             addr;
  logic                      addr_ok;
  logic                      have_data;
  logic [7:0]                wr_byte;
  logic [2:0]                tx_idx;
  logic [7:0]                tx_sh;
  logic                      busy;
  logic                      write_enable_latch;
  logic                      restored;
  logic [7:0]                status_byte;
  logic [2:0]                lvl;
  logic                      locked;
  logic                      done_cmd;
  flash_guard_pkg::op_kind_t next_kind;
  logic                      is_write_op;
  logic                      permit;

  pin_sync #(
    .WIDTH (5),
    .INIT  (`PIN_SYNC_INIT)
  ) u_pin_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   ({select_n, sck, si, pause_request_n, write_guard_n}),
    .level (sync_level)
  );

  assign {cs_s, sck_s, si_s, hold_s, guard_s} = sync_level;
  assign active   = !cs_s && !paused;
  assign sck_rise = sck_s && !sck_q && active;
  assign sck_fall = !sck_s && sck_q && active;
  assign cs_rise  = cs_s && !cs_q;
  assign rx_byte  = {shreg[6:0], si_s};  // R22
  assign lvl      = nv_bits[`STAT_LEVEL_HI:`STAT_LEVEL_LO];
  assign locked   = !guard_s && nv_bits[`STAT_LOCK];  // R8
  assign status_byte = (nv_bits & `STAT_NV_MASK) | {6'h00, write_enable_latch, busy}; // R13

  // Previous levels for edge finding
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q   <= 1'b1;
      sck_q  <= 1'b0;
      hold_q <= 1'b1;
    end else begin
      cs_q   <= cs_s;
      sck_q  <= sck_s;
      hold_q <= hold_s;
    end
  end

  // Pause entry and exit, both only with the clock low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      paused <= 1'b0;
    end else if (hold_q && !hold_s && !sck_s && !cs_s) begin
      paused <= 1'b1;  // R4
    end else if (hold_s && !sck_s && !cs_s) begin
      paused <= 1'b0;  // R4 R7
    end
  end

  // Command framing, sampled on rising clock edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase     <= flash_guard_pkg::st_cmd;
      bit_cnt   <= 3'h0;
      addr_cnt  <= 2'h0;
      shreg     <= 8'h00;
      cmd       <= 8'h00;
      addr      <= '0;
      addr_ok   <= 1'b0;
      have_data <= 1'b0;
      wr_byte   <= 8'h00;
    end else if (cs_s) begin
      phase     <= flash_guard_pkg::st_cmd;  // R7 R22
      bit_cnt   <= 3'h0;
      addr_cnt  <= 2'h0;
      addr_ok   <= 1'b0;
      have_data <= 1'b0;
    end else if (sck_rise) begin
      shreg   <= rx_byte;  // R1 R2
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        unique case (phase)
          flash_guard_pkg::st_cmd: begin
            cmd <= rx_byte;
            unique case (rx_byte)
              `CMD_STATUS_READ:  phase <= flash_guard_pkg::st_read;  // R21
              `CMD_STATUS_WRITE: phase <= flash_guard_pkg::st_data;  // R21
              `CMD_PAGE_PROGRAM, `CMD_SECTOR_ERASE,
              `CMD_SECTOR_ERASE_B, `CMD_BLOCK_ERASE:
                phase <= flash_guard_pkg::st_addr;
              default: phase <= flash_guard_pkg::st_ignore;
            endcase
          end
          flash_guard_pkg::st_addr: begin
            addr     <= {addr[AW-9:0], rx_byte};  // R22
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == `ADDR_LAST_BYTE) begin
              addr_ok <= 1'b1;
              phase   <= (cmd == `CMD_PAGE_PROGRAM) ?
                         flash_guard_pkg::st_data :
                         flash_guard_pkg::st_ignore;
            end
          end
          flash_guard_pkg::st_data: begin
            if (!have_data) begin
              wr_byte <= rx_byte;  // R21
            end
            have_data <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Status stream, driven after falling clock edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      so     <= 1'b0;
      so_oe  <= 1'b0;
      tx_idx <= 3'h0;
      tx_sh  <= 8'h00;
    end else begin
      so_oe <= active && phase == flash_guard_pkg::st_read;  // R6
      if (cs_s) begin
        tx_idx <= 3'h0;
      end else if (sck_fall && phase == flash_guard_pkg::st_read) begin
        tx_idx <= tx_idx + 3'h1;  // R21
        if (tx_idx == 3'h0) begin
          so    <= status_byte[7];  // R1 R10
          tx_sh <= {status_byte[6:0], 1'b0};
        end else begin
          so    <= tx_sh[7];
          tx_sh <= {tx_sh[6:0], 1'b0};
        end
      end
    end
  end

  always_comb begin
    next_kind   = flash_guard_pkg::op_program;
    is_write_op = 1'b1;
    unique case (cmd)
      `CMD_PAGE_PROGRAM: begin
        next_kind   = flash_guard_pkg::op_program;
        is_write_op = addr_ok && have_data;
      end
      `CMD_SECTOR_ERASE, `CMD_SECTOR_ERASE_B: begin
        next_kind   = flash_guard_pkg::op_sector;
        is_write_op = addr_ok;
      end
      `CMD_BLOCK_ERASE: begin
        next_kind   = flash_guard_pkg::op_block;
        is_write_op = addr_ok;
      end
      `CMD_CHIP_ERASE, `CMD_CHIP_ERASE_B: begin
        next_kind = flash_guard_pkg::op_chip;
      end
      default: begin
        is_write_op = 1'b0;
      end
    endcase
  end

  assign permit = write_enable_latch && !busy && (next_kind == flash_guard_pkg::op_chip ?
                  lvl == 3'h0 :                                  // R16
                  !is_protected(addr, lvl, nv_bits[`STAT_FROM_BOTTOM]));
  assign done_cmd = cs_rise && !paused && bit_cnt == 3'h0 &&
                    phase != flash_guard_pkg::st_cmd && !busy;  // R10 R22

  // Program data toward the array, only for a permitted target
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_valid <= 1'b0;
      prog_data  <= 8'h00;
    end else begin
      prog_valid <= sck_rise && bit_cnt == 3'h7 && addr_ok &&
                    phase == flash_guard_pkg::st_data && permit;  // R15 R23
      prog_data  <= rx_byte;
    end
  end

  // Status bits, write latch, busy and launch of array operations
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv_bits  <= `NV_RESET;
      restored <= 1'b0;
      write_enable_latch      <= 1'b0;  // R12
      busy     <= 1'b0;
      op_start <= 1'b0;
      op_kind  <= flash_guard_pkg::op_program;
      op_addr  <= '0;
      nv_store <= 1'b0;
    end else begin
      op_start <= 1'b0;
      nv_store <= 1'b0;
      if (!restored) begin
        nv_bits  <= nv_restore & `STAT_NV_MASK;  // R14
        restored <= 1'b1;
      end
      if (busy && array_done) begin
        busy <= 1'b0;  // R9
        write_enable_latch  <= 1'b0;  // R12
      end
      if (done_cmd && restored) begin
        unique case (cmd)
          `CMD_WRITE_ENABLE:  write_enable_latch <= 1'b1;
          `CMD_WRITE_DISABLE: write_enable_latch <= 1'b0;  // R12
          `CMD_STATUS_WRITE: begin
            if (have_data && write_enable_latch && !locked) begin  // R8 R23
              nv_bits  <= wr_byte & `STAT_NV_MASK;  // R13 R14
              nv_store <= 1'b1;
              write_enable_latch      <= 1'b0;  // R12
            end
          end
          default: begin
            if (is_write_op && permit) begin  // R11 R15 R16 R23
              busy     <= 1'b1;  // R9
              op_start <= 1'b1;
              op_kind  <= next_kind;
              op_addr  <= addr;
            end
          end
        endcase
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_float_paused; paused |=> !so_oe; endproperty
  a_float_paused: assert property (p_float_paused) // R6
    else $error("output driven while paused");
  property p_pause_entry;
    $fell(hold_s) && !sck_s && !cs_s |=> paused; endproperty
  a_pause_entry: assert property (p_pause_entry) // R4
    else $error("pause not entered");
  property p_pause_hold; paused && !hold_s |=> paused; endproperty
  a_pause_hold: assert property (p_pause_hold) // R7
    else $error("pause left with request low");
  property p_busy_launch; op_start |-> busy && !$past(busy); endproperty
  a_busy_launch: assert property (p_busy_launch) // R9
    else $error("busy flag not set at launch");
  property p_latch_gate; op_start |-> $past(write_enable_latch); endproperty
  a_latch_gate: assert property (p_latch_gate) // R11
    else $error("operation launched with latch clear");
  property p_latch_clear; busy && array_done |=> !write_enable_latch && !busy; endproperty
  a_latch_clear: assert property (p_latch_clear) // R12
    else $error("latch or busy kept after completion");
  property p_lock_guard;
    nv_store |-> $past(guard_s) || !$past(nv_bits[`STAT_LOCK]); endproperty
  a_lock_guard: assert property (p_lock_guard) // R8
    else $error("status written while locked");
  property p_region; op_start && op_kind != flash_guard_pkg::op_chip |->
    !is_protected(op_addr, lvl, nv_bits[`STAT_FROM_BOTTOM]); endproperty
  a_region: assert property (p_region) // R15
    else $error("operation launched into protected region");
  property p_chip;
    op_start && op_kind == flash_guard_pkg::op_chip |-> lvl == 3'h0; endproperty
  a_chip: assert property (p_chip) // R16
    else $error("chip erase launched while protected");
  property p_reserved; !status_byte[`STAT_RESERVED]; endproperty
  a_reserved: assert property (p_reserved) // R13
    else $error("reserved status bit set");

  c_launch: cover property (op_start);
  c_store: cover property (nv_store);
  c_stream: cover property (so_oe ##1 so_oe);
  c_resume: cover property ($fell(paused));

endmodule : spi_flash_protect_status

/* File: verification/spi_master_model.sv */
// SPI bus master model: frames, bytes and pause on the serial pins.
// Assumes the bench calls its tasks; pins move on mclk falls, sck half 4 mclk.
`timescale 1ns/10ps
module spi_master_model (
  input  wire logic mclk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      sck,
  output logic      select_n,
  output logic      si,
  output logic      pause_request_n
);
  logic idle_hi;

  initial begin
    idle_hi         = 1'b0;
    sck             = 1'b0;
    select_n        = 1'b1;
    si              = 1'b1;
    pause_request_n = 1'b1;
  end

  task automatic half();
    repeat (4) @(negedge mclk);
  endtask : half

  task automatic park(input logic hi);
    idle_hi = hi;
    sck     = hi;
    half();
  endtask : park

  task automatic open_frame();
    select_n = 1'b0;
    half();
  endtask : open_frame

  task automatic close_frame();
    sck = idle_hi;
    half();
    select_n = 1'b1;
    si       = ~si;
    repeat (8) @(negedge mclk);
  endtask : close_frame

  // Data set while sck low, taken at the rise, so read at end of high
  task automatic xfer(input logic [7:0] b, input int hi, input int lo,
                      inout logic [7:0] r);
    for (int i = hi; i >= lo; i--) begin
      sck = 1'b0;
      si  = b[i];
      half();
      sck = 1'b1;
      half();
      r[i] = so_oe ? so : ~so;
    end
  endtask : xfer

  // Pause request moves only with sck low; sck and si wiggle meanwhile
  task automatic pause_on();
    sck = 1'b0;
    half();
    half();
    pause_request_n = 1'b0;
    half();
    for (int i = 0; i < 4; i++) begin
      sck = ~sck;
      si  = ~si;
      half();
    end
  endtask : pause_on

  task automatic pause_off();
    pause_request_n = 1'b1;
    half();
  endtask : pause_off
endmodule : spi_master_model

/* File: verification/spi_flash_protect_status_test.sv */
// Bench for the serial flash front end: protection table, lock, pause.
// Assumes spi_master_model on the pins; the bench stands in for the array.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module spi_flash_protect_status_test;
  typedef struct packed {
    logic [7:0]  st;
    logic [7:0]  cmd;
    logic [18:0] addr;
    logic        go;
  } row_t;

  logic                      mclk, rst_n, sck, select_n, si, pause_request_n;
  logic                      write_guard_n, array_done, so, so_oe, op_start;
  logic                      prog_valid, nv_store;
  logic [7:0]                nv_restore, prog_data, nv_bits, data_seen;
  logic [18:0]               op_addr, addr_seen;
  flash_guard_pkg::op_kind_t op_kind, kind_seen;
  int                        n_fail, n_compared, n_start, n_store, n_prog;
  int                        s, p;
  row_t                      rw;
  row_t                      rows [14];

  spi_flash_protect_status dut_u (.mclk(mclk), .rst_n(rst_n), .sck(sck),
    .select_n(select_n), .si(si), .pause_request_n(pause_request_n),
    .write_guard_n(write_guard_n), .array_done(array_done),
    .nv_restore(nv_restore), .so(so), .so_oe(so_oe), .op_start(op_start),
    .op_kind(op_kind), .op_addr(op_addr), .prog_data(prog_data),
    .prog_valid(prog_valid), .nv_store(nv_store), .nv_bits(nv_bits));
  spi_master_model m_u (.mclk(mclk), .so(so), .so_oe(so_oe), .sck(sck),
    .select_n(select_n), .si(si), .pause_request_n(pause_request_n));

  always #10 mclk = ~mclk;

  always @(negedge mclk) begin
    if (op_start === 1'b1) begin
      n_start++;
      kind_seen = op_kind;
      addr_seen = op_addr;
    end
    if (nv_store === 1'b1) n_store++;
    if (prog_valid === 1'b1) begin
      n_prog++;
      data_seen = prog_data;
    end
  end

  function automatic flash_guard_pkg::op_kind_t kind_of(logic [7:0] c);
    case (c)
      8'h02:        return flash_guard_pkg::op_program;
      8'hd8:        return flash_guard_pkg::op_block;
      8'h60, 8'hc7: return flash_guard_pkg::op_chip;
      default:      return flash_guard_pkg::op_sector;
    endcase
  endfunction : kind_of

  task automatic frame(input logic [39:0] w, input int n);
    logic [7:0] r;
    m_u.open_frame();
    for (int k = 0; k < n; k++) m_u.xfer(w[39-8*k -: 8], 7, 0, r);
    m_u.close_frame();
  endtask : frame

  task automatic status_read_cmd(input logic [7:0] e, input logic hold);
    logic [7:0] r, t;
    m_u.open_frame();
    m_u.xfer(8'h05, 7, 0, r);
    m_u.xfer(8'h00, 7, 4, r);
    if (hold) begin
      m_u.pause_on();
      `CHK("so_oe paused", 1'b0, so_oe)
      m_u.pause_off();
    end
    m_u.xfer(8'h00, 3, 0, r);
    `CHK("status", e, r)
    m_u.xfer(8'h00, 7, 0, t);
    `CHK("status again", e, t)
    m_u.close_frame();
  endtask : status_read_cmd

  task automatic do_reset(input logic [7:0] nv);
    rst_n      = 1'b0;
    nv_restore = nv;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : do_reset

  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    $display("[FAIL] watchdog exp done got hang");
    final_report();
  end

  initial begin
    mclk = 1'b0;
    write_guard_n = 1'b1;
    array_done = 1'b0;
    n_fail = 0;
    n_compared = 0;
    n_start = 0;
    n_store = 0;
    n_prog = 0;
    rows = '{'{8'h43, 8'h20, 19'h7f000, 1'b1}, '{8'h20, 8'hd8, 19'h0, 1'b1},
      '{8'h04, 8'h20, 19'h70000, 1'b0}, '{8'h04, 8'h02, 19'h6f000, 1'b1},
      '{8'h08, 8'hd7, 19'h60000, 1'b0}, '{8'h0c, 8'h20, 19'h3f000, 1'b1},
      '{8'h0c, 8'hd8, 19'h40000, 1'b0}, '{8'h24, 8'h02, 19'h0f000, 1'b0},
      '{8'h24, 8'h20, 19'h10000, 1'b1}, '{8'h28, 8'h20, 19'h1f000, 1'b0},
      '{8'h2c, 8'hd8, 19'h40000, 1'b1}, '{8'h10, 8'h20, 19'h0, 1'b0},
      '{8'h04, 8'h60, 19'h0, 1'b0}, '{8'h00, 8'hc7, 19'h0, 1'b1}};
    do_reset(8'h00);
    for (int k = 0; k < 14; k++) begin
      rw = rows[k];
      frame({8'h06, 32'h0}, 1);
      s = n_store;
      frame({8'h01, rw.st, 24'h0}, 2);
      `CHK("nv_bits", rw.st & 8'hbc, nv_bits)
      `CHK("nv_store", s + 1, n_store)
      frame({8'h06, 32'h0}, 1);
      s = n_start;
      p = n_prog;
      frame({rw.cmd, 5'h0, rw.addr, 8'h5a}, rw.cmd == 8'h02 ? 5 :
            (kind_of(rw.cmd) == flash_guard_pkg::op_chip ? 1 : 4));
      `CHK("launch", s + rw.go, n_start)
      `CHK("prog", p + (rw.go && rw.cmd == 8'h02), n_prog)
      if (rw.go) begin
        `CHK("kind", kind_of(rw.cmd), kind_seen)
        if (rw.cmd != 8'h60 && rw.cmd != 8'hc7)
          `CHK("addr", rw.addr, addr_seen)
        if (rw.cmd == 8'h02) `CHK("data", 8'h5a, data_seen)
        status_read_cmd((rw.st & 8'hbc) | 8'h03, 1'b0);
        @(negedge mclk) array_done = 1'b1;
        @(negedge mclk) array_done = 1'b0;
        repeat (4) @(negedge mclk);
        status_read_cmd(rw.st & 8'hbc, 1'b0);
      end else status_read_cmd((rw.st & 8'hbc) | 8'h02, 1'b0);
    end
    frame({8'h06, 32'h0}, 1);
    frame({8'h04, 32'h0}, 1);
    s = n_start;
    frame({8'h20, 32'h0}, 4);
    `CHK("no latch", s, n_start)
    frame({8'h06, 32'h0}, 1);
    frame({8'h01, 8'h80, 24'h0}, 2);
    write_guard_n = 1'b0;
    frame({8'h06, 32'h0}, 1);
    s = n_store;
    frame({8'h01, 8'h00, 24'h0}, 2);
    `CHK("locked", 8'h80, nv_bits)
    `CHK("locked store", s, n_store)
    write_guard_n = 1'b1;
    frame({8'h01, 8'h00, 24'h0}, 2);
    `CHK("unlocked", 8'h00, nv_bits)
    frame({8'h06, 32'h0}, 1);
    m_u.open_frame();
    m_u.xfer(8'h01, 7, 0, rw.st);
    m_u.xfer(8'hff, 7, 4, rw.st);
    m_u.close_frame();
    `CHK("aborted", 8'h00, nv_bits)
    m_u.park(1'b1);
    status_read_cmd(8'h02, 1'b1);
    m_u.park(1'b0);
    m_u.open_frame();
    m_u.xfer(8'h04, 7, 0, rw.st);
    m_u.pause_on();
    m_u.close_frame();
    m_u.pause_off();
    status_read_cmd(8'h02, 1'b0);
    do_reset(8'hff);
    `CHK("restored", 8'hbc, nv_bits)
    status_read_cmd(8'hbc, 1'b0);
    final_report();
  end
endmodule : spi_flash_protect_status_test
